// ### src/cbt_transceiver.sv
// Eight-lane configurable bus transceiver with Wishbone control registers.
// Assumes the pins are asynchronous and the bus is classic Wishbone on core_clk.
//
// Overview of operation
// - Eight lanes: split TTL, shared backplane bit
// - Two select bits pick each element kind
// - Buffer mode outputs inverted input, unclocked
// - Flip-flop captures input on rise, outputs inverted
// - Latch transparent while clock high, else holds
// - Return select low: backplane feeds return element
// - Return select high: forward element feeds return
// - Return_path_select carries TTL input to TTL output
// - TTL outputs drive only when enabled
// - Backplane drives only with both enables right
// - Elements keep working while outputs disabled
//
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none

module cbt_transceiver #(
  parameter int LANES = cbt_pkg::CBT_LANES
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [cbt_pkg::CBT_ADDR_W-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [cbt_pkg::CBT_DATA_W-1:0] wb_dat_w,
  output logic [cbt_pkg::CBT_DATA_W-1:0] wb_dat_r,
  output logic wb_ack,
  // Direction clocks from pins
  input wire logic a_to_b_clock,
  input wire logic b_to_a_clock,
  // TTL side, split input and output
  input wire logic [LANES-1:0] ttl_in_bus,
  output logic [LANES-1:0] ttl_out_bus,
  output logic [LANES-1:0] ttl_out_oe_n,
  // Backplane side, open collector per lane
  input wire logic [LANES-1:0] bp_line_in,
  output logic [LANES-1:0] bp_line_out,
  output logic [LANES-1:0] bp_line_oe_n
);
  import cbt_pkg::*;

  // Control register and its fields
  logic [CBT_CTRL_W-1:0] ctrl_ff;
  logic a_to_b_sel_hi;
  logic a_to_b_sel_lo;
  logic b_to_a_sel_hi;
  logic b_to_a_sel_lo;
  logic return_path_select;
  logic a_output_enable;
  logic b_output_enable;
  logic b_output_enable_n;

  // Synchronised pins
  logic [1:0] clk_stable;
  logic [LANES-1:0] ttl_in_stable;
  logic [LANES-1:0] bp_in_stable;

  // Direction clock edge detection
  logic [1:0] clk_prev_ff;
  logic a_to_b_rise;
  logic b_to_a_rise;

  // Element data
  logic [LANES-1:0] fwd_stored;
  logic [LANES-1:0] ret_stored;
  logic [LANES-1:0] ret_source;
  logic [LANES-1:0] fwd_drive;
  logic [LANES-1:0] ret_drive;

  // Output registers
  logic [LANES-1:0] ttl_out_ff;
  logic [LANES-1:0] ttl_oe_n_ff;
  logic [LANES-1:0] bp_oe_n_ff;
  logic bp_active;

  // Bus slave state
  logic ack_ff;
  logic [CBT_DATA_W-1:0] rdata_ff;
  logic bus_req;
  logic hit_ctrl;
  logic hit_status;
  logic [CBT_DATA_W-1:0] status_word;

  // Field breakout of the control register
  assign a_to_b_sel_lo = ctrl_ff[CBT_CTRL_AB_LO];
  assign a_to_b_sel_hi = ctrl_ff[CBT_CTRL_AB_HI];
  assign b_to_a_sel_lo = ctrl_ff[CBT_CTRL_BA_LO];
  assign b_to_a_sel_hi = ctrl_ff[CBT_CTRL_BA_HI];
  assign return_path_select = ctrl_ff[CBT_CTRL_RETURN];
  assign a_output_enable = ctrl_ff[CBT_CTRL_A_OE];
  assign b_output_enable = ctrl_ff[CBT_CTRL_B_OE];
  assign b_output_enable_n = ctrl_ff[CBT_CTRL_B_OE_N];

  // Direction clocks pass the same filter as data so edges line up with samples
  cbt_sync #(
    .WIDTH(2),
    .RESET_VAL(2'h0)
  ) u_clk_sync (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .pin_async({b_to_a_clock, a_to_b_clock}),
    .pin_stable(clk_stable)
  );

  cbt_sync #(
    .WIDTH(LANES),
    .RESET_VAL(CBT_TTL_IN_RST)
  ) u_ttl_sync (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .pin_async(ttl_in_bus),
    .pin_stable(ttl_in_stable)
  );

  cbt_sync #(
    .WIDTH(LANES),
    .RESET_VAL(CBT_BP_IN_RST)
  ) u_bp_sync (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .pin_async(bp_line_in),
    .pin_stable(bp_in_stable)
  );

  // Previous filtered clock levels for rising edge detection
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clk_prev_ff <= 2'h0;
    end else if (clk_en) begin
      clk_prev_ff <= clk_stable;
    end
  end

  assign a_to_b_rise = clk_stable[0] & ~clk_prev_ff[0];
  assign b_to_a_rise = clk_stable[1] & ~clk_prev_ff[1];

  cbt_element #(
    .WIDTH(LANES),
    .RESET_VAL(CBT_STORE_RST)
  ) u_fwd_elem (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .sel_hi(a_to_b_sel_hi),
    .sel_lo(a_to_b_sel_lo),
    .dir_clk_level(clk_stable[0]),
    .dir_clk_rise(a_to_b_rise),
    .data_in(ttl_in_stable),
    .stored(fwd_stored)
  );

  assign ret_source = return_path_select ? fwd_stored : bp_in_stable;

  cbt_element #(
    .WIDTH(LANES),
    .RESET_VAL(CBT_STORE_RST)
  ) u_ret_elem (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .sel_hi(b_to_a_sel_hi),
    .sel_lo(b_to_a_sel_lo),
    .dir_clk_level(clk_stable[1]),
    .dir_clk_rise(b_to_a_rise),
    .data_in(ret_source),
    .stored(ret_stored)
  );

  // Final inversion of each element toward its pins
  // inverted element output
  assign fwd_drive = ~fwd_stored;
  assign ret_drive = ~ret_stored;

  assign bp_active = b_output_enable & ~b_output_enable_n;

  // TTL output data always tracks the element, so enabling shows fresh data
  // return_path_select reaches TTL output
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ttl_out_ff <= '0;
    end else if (clk_en) begin
      ttl_out_ff <= ret_drive;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ttl_oe_n_ff <= '1;
    end else if (clk_en) begin
      ttl_oe_n_ff <= {LANES{~a_output_enable}};
    end
  end

  // Open collector: a one is never driven, the pull-up supplies it
  // pull low on zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bp_oe_n_ff <= '1;
    end else if (clk_en) begin
      bp_oe_n_ff <= ~({LANES{bp_active}} & ~fwd_drive);
    end
  end

  assign ttl_out_bus = ttl_out_ff;
  assign ttl_out_oe_n = ttl_oe_n_ff;
  assign bp_line_out = '0;
  assign bp_line_oe_n = bp_oe_n_ff;

  // Bus decode; the top bits of the address select nothing else
  assign bus_req = wb_cyc & wb_stb & ~ack_ff;
  assign hit_ctrl = (wb_adr == CBT_CTRL_OFS);
  assign hit_status = (wb_adr == CBT_STATUS_OFS);

  // Status gives software a view of both stores and the filtered pins
  always_comb begin
    status_word = '0;
    status_word[CBT_ST_AB_POS +: LANES] = fwd_stored;
    status_word[CBT_ST_BA_POS +: LANES] = ret_stored;
    status_word[CBT_ST_TTL_POS +: LANES] = ttl_in_stable;
    status_word[CBT_ST_BP_POS +: LANES] = bp_in_stable;
  end

  // Control write on lane zero; a write to status or an unmapped word is dropped
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= CBT_CTRL_RST;
    end else if (clk_en) begin
      if (bus_req && wb_we && hit_ctrl && wb_sel[0]) begin
        ctrl_ff <= wb_dat_w[CBT_CTRL_W-1:0];
      end
    end
  end

  // One wait state, ack for one cycle; unmapped reads return zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
    end else if (clk_en) begin
      ack_ff <= bus_req;
    end
  end

  // Read data latched with a read request, held until the next read request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= '0;
    end else if (clk_en) begin
      if (bus_req && !wb_we) begin
        if (hit_ctrl) begin
          rdata_ff <= {{(CBT_DATA_W-CBT_CTRL_W){1'b0}}, ctrl_ff};
        end else if (hit_status) begin
          rdata_ff <= status_word;
        end else begin
          rdata_ff <= '0;
        end
      end
    end
  end

  assign wb_ack = ack_ff;
  assign wb_dat_r = rdata_ff;

endmodule // cbt_transceiver

`default_nettype wire

// ### shared/cbt_pkg.sv
// Constants, register map and mode decode for the eight-lane bus transceiver.
// Assumes a 32-bit classic Wishbone register bus and a single core clock.
package cbt_pkg;

  // Lane count and bus widths
  localparam int CBT_LANES = 8;
  localparam int CBT_ADDR_W = 4;
  localparam int CBT_DATA_W = 32;

  // Synchroniser depth for pin inputs
  localparam int CBT_SYNC_STAGES = 3;

  // Register byte offsets
  localparam logic [CBT_ADDR_W-1:0] CBT_CTRL_OFS = 4'h0;
  localparam logic [CBT_ADDR_W-1:0] CBT_STATUS_OFS = 4'h4;

  // Control register field positions
  localparam int CBT_CTRL_AB_LO = 0;
  localparam int CBT_CTRL_AB_HI = 1;
  localparam int CBT_CTRL_BA_LO = 2;
  localparam int CBT_CTRL_BA_HI = 3;
  localparam int CBT_CTRL_RETURN = 4;
  localparam int CBT_CTRL_A_OE = 5;
  localparam int CBT_CTRL_B_OE = 6;
  localparam int CBT_CTRL_B_OE_N = 7;
  localparam int CBT_CTRL_W = 8;

  // Control reset: buffer modes, no return_path_select, both sides isolated
  localparam logic [CBT_CTRL_W-1:0] CBT_CTRL_RST = 8'h80;

  // Status register field positions
  localparam int CBT_ST_AB_POS = 0;
  localparam int CBT_ST_BA_POS = 8;
  localparam int CBT_ST_TTL_POS = 16;
  localparam int CBT_ST_BP_POS = 24;

  // Reset levels of synchronised pins and element stores: released backplane reads high
  localparam logic [CBT_LANES-1:0] CBT_TTL_IN_RST = 8'h00;
  localparam logic [CBT_LANES-1:0] CBT_BP_IN_RST = 8'hff;
  localparam logic [CBT_LANES-1:0] CBT_STORE_RST = 8'h00;

  // Logic element kinds
  typedef enum logic [1:0] {
    CBT_BUFFER,
    CBT_FLIPFLOP,
    CBT_LATCH
  } cbt_mode_t;

  // High-order select wins; low-order only splits buffer from flip-flop
  function automatic cbt_mode_t cbt_decode(input logic sel_hi, input logic sel_lo);
    if (sel_hi) begin
      return CBT_LATCH;
    end else if (sel_lo) begin
      return CBT_FLIPFLOP;
    end else begin
      return CBT_BUFFER;
    end
  endfunction

endpackage

// ### src/cbt_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes its inputs are asynchronous to core_clk.
`timescale 1ns/100ps
`default_nettype none

module cbt_sync #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Pin side
  input wire logic [WIDTH-1:0] pin_async,
  // Core side
  output logic [WIDTH-1:0] pin_stable
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] stable_ff;

  // Shift chain; the first stage feeds only the second
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_ff <= RESET_VAL;
      s2_ff <= RESET_VAL;
      s3_ff <= RESET_VAL;
    end else if (clk_en) begin
      meta_ff <= pin_async;
      s2_ff <= meta_ff;
      s3_ff <= s2_ff;
    end
  end

  // A bit changes only once stages two and three agree, filtering a one-cycle glitch
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stable_ff <= RESET_VAL;
    end else if (clk_en) begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          stable_ff[i] <= s3_ff[i];
        end
      end
    end
  end

  assign pin_stable = stable_ff;

endmodule // cbt_sync

`default_nettype wire

// ### src/cbt_element.sv
// One direction's selectable logic element: buffer, edge flip-flop or latch.
// Holds true (non-inverted) data; the caller inverts toward the pins.
`timescale 1ns/100ps
`default_nettype none

module cbt_element #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Mode select pair
  input wire logic sel_hi,
  input wire logic sel_lo,
  // Direction clock, already synchronised
  input wire logic dir_clk_level,
  input wire logic dir_clk_rise,
  // Data
  input wire logic [WIDTH-1:0] data_in,
  output logic [WIDTH-1:0] stored
);
  import cbt_pkg::*;

  cbt_mode_t mode;
  logic [WIDTH-1:0] store_ff;

  assign mode = cbt_decode(sel_hi, sel_lo);

  // Runs whatever the output enables say, so data can be loaded while isolated
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      store_ff <= RESET_VAL;
    end else if (clk_en) begin
      unique case (mode)
        CBT_BUFFER: begin
          store_ff <= data_in;
        end
        CBT_FLIPFLOP: begin
          if (dir_clk_rise) begin
            store_ff <= data_in;
          end
        end
        CBT_LATCH: begin
          if (dir_clk_level) begin
            store_ff <= data_in;
          end
        end
      endcase
    end
  end

  assign stored = store_ff;

endmodule // cbt_element

`default_nettype wire

// ### sim/cbt_bp_model.sv
// Backplane partner: other open-collector cards plus the pull-up.
// Assumes one transceiver under test on the shared lanes.
`timescale 1ns/100ps
`default_nettype none
module cbt_bp_model #(
  parameter int LANES = 8
) (
  // Transceiver under test
  input wire logic [LANES-1:0] line_out,
  input wire logic [LANES-1:0] line_oe_n,
  // Other cards sinking lanes
  input wire logic [LANES-1:0] other_pull,
  // Resolved wire
  output logic [LANES-1:0] wire_level
);
  // Pull-up wins unless some card sinks the lane
  assign wire_level = ~(other_pull | (~line_oe_n & ~line_out));
endmodule // cbt_bp_model
`default_nettype wire

// ### sim/cbt_transceiver_chk.sv
// Pin and bus checks for the transceiver.
// Assumes it is bound into cbt_transceiver and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module cbt_transceiver_chk #(
  parameter int LANES = 8
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Register bus
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [cbt_pkg::CBT_ADDR_W-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [cbt_pkg::CBT_DATA_W-1:0] wb_dat_w,
  input wire logic wb_ack,
  // Pins
  input wire logic [LANES-1:0] ttl_in_bus,
  input wire logic [LANES-1:0] ttl_out_bus,
  input wire logic [LANES-1:0] ttl_out_oe_n,
  input wire logic [LANES-1:0] bp_line_in,
  input wire logic [LANES-1:0] bp_line_out,
  input wire logic [LANES-1:0] bp_line_oe_n
);
  import cbt_pkg::*;
  logic [7:0] ctrl_ff;
  logic [3:0] quiet_ff;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Shadow of the control byte, taken at the acked write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_ff <= CBT_CTRL_RST;
    end else if (wb_cyc && wb_stb && wb_we && wb_ack && wb_adr == CBT_CTRL_OFS && wb_sel[0]) begin
      ctrl_ff <= wb_dat_w[7:0];
    end
  end
  // Quiet time; saturates so a long idle never wraps to zero, and a frozen cycle restarts it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      quiet_ff <= 4'h0;
    end else if (!clk_en || $changed(ttl_in_bus) || $changed(bp_line_in) || $changed(ctrl_ff)) begin
      quiet_ff <= 4'h0;
    end else if (quiet_ff != 4'hf) begin
      quiet_ff <= quiet_ff + 4'h1;
    end
  end
  sequence s_req;
    wb_cyc && wb_stb && !wb_ack && clk_en ##1 clk_en;
  endsequence
  // Stability is also tested directly: the counter lags a change by one edge
  sequence s_settled;
    quiet_ff >= 4'ha && $stable(ctrl_ff) && $stable(ttl_in_bus) && $stable(bp_line_in);
  endsequence
  a_ack_timing: assert property (s_req |-> wb_ack ##1 !wb_ack)
    else $error("ack not a single pulse after request");
  a_open_drain: assert property (bp_line_out == '0)
    else $error("backplane driven high");
  a_oe_uniform: assert property (ttl_out_oe_n == '0 || ttl_out_oe_n == '1)
    else $error("ttl enables differ");
  a_a_enable: assert property (s_settled |-> ttl_out_oe_n == {LANES{!ctrl_ff[5]}})
    else $error("ttl enable wrong");
  a_b_gated: assert property (s_settled ##0 !(ctrl_ff[6] && !ctrl_ff[7]) |-> bp_line_oe_n == '1)
    else $error("backplane pulled while inactive");
  a_fwd_buffer: assert property (s_settled ##0 (ctrl_ff[1:0] == 2'b00 && ctrl_ff[7:6] == 2'b01)
    |-> bp_line_oe_n == ~ttl_in_bus)
    else $error("forward buffer wrong");
  a_ret_buffer: assert property (s_settled ##0 ctrl_ff[4:2] == 3'b000 |-> ttl_out_bus == ~bp_line_in)
    else $error("return buffer wrong");
  a_loop_buffer: assert property (s_settled ##0 ctrl_ff[4:0] == 5'h10 |-> ttl_out_bus == ~ttl_in_bus)
    else $error("return_path_select buffer wrong");
endmodule // cbt_transceiver_chk
bind cbt_transceiver cbt_transceiver_chk #(.LANES(LANES)) i_chk (.core_clk(core_clk), .rst(rst),
  .clk_en(clk_en), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
  .wb_dat_w(wb_dat_w), .wb_ack(wb_ack), .ttl_in_bus(ttl_in_bus), .ttl_out_bus(ttl_out_bus),
  .ttl_out_oe_n(ttl_out_oe_n), .bp_line_in(bp_line_in), .bp_line_out(bp_line_out), .bp_line_oe_n(bp_line_oe_n));
`default_nettype wire

// ### sim/cbt_transceiver_tb_top.sv
// Testbench: registers, enables, element modes, return_path_select.
// Assumes the backplane model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module cbt_transceiver_tb_top;
  import cbt_pkg::*;
  logic core_clk = 0, rst = 1, clk_en = 1, wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack, ab_clk = 0, ba_clk = 0;
  logic [3:0] wb_adr = '0, wb_sel = '0;
  logic [31:0] wb_dat_w = '0, wb_dat_r, rd;
  logic [7:0] ttl_in = '0, ttl_out, ttl_oe_n, bp_in, bp_out, bp_oe_n, pull = '0;
  int n_mismatch = 0, total_checks = 0;
  cbt_transceiver #(.LANES(8)) i_dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .a_to_b_clock(ab_clk), .b_to_a_clock(ba_clk),
    .ttl_in_bus(ttl_in), .ttl_out_bus(ttl_out), .ttl_out_oe_n(ttl_oe_n), .bp_line_in(bp_in),
    .bp_line_out(bp_out), .bp_line_oe_n(bp_oe_n));
  cbt_bp_model #(.LANES(8)) i_bp (.line_out(bp_out), .line_oe_n(bp_oe_n), .other_pull(pull),
    .wire_level(bp_in));
  // Free-running core clock
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk_pin(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic chk_reg(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Classic cycle: hold everything until ack is seen, then idle one cycle
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    wb_sel <= s;
    // No cycle budget here: a missing ack is left to the watchdog
    do begin
      @(posedge core_clk);
    end while (wb_ack !== 1'b1);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge core_clk);
  endtask
  // Value held by an element after each phase of the run below
  function automatic logic [7:0] exp_store(input logic [1:0] m, input int ph, input logic [7:0] d1, d2, d3);
    if (ph == 0) return (m == 2'b00) ? d2 : d1;
    if (ph == 1) return d2;
    return (m == 2'b01) ? d2 : d3;
  endfunction
  task automatic set_clk(input logic fwd, input logic v);
    if (fwd) ab_clk <= v;
    else ba_clk <= v;
  endtask
  // Capture with the output off, then enable it and step the clock and data
  task automatic run(input logic fwd, input logic [1:0] m);
    logic [7:0] d1, d2, d3, c, e;
    d1 = 8'($urandom);
    d2 = ~d1;
    d3 = d1 ^ 8'h5a;
    c = fwd ? {6'h00, m} : {4'h1, m, 2'b00};
    bus(1'b1, CBT_CTRL_OFS, {24'h0, c}, 4'h1);
    ttl_in <= d1;
    pull <= 8'($urandom);
    wait_n(8);
    set_clk(fwd, 1'b1);
    wait_n(8);
    set_clk(fwd, 1'b0);
    wait_n(8);
    bus(1'b1, CBT_CTRL_OFS, {24'h0, c | (fwd ? 8'h40 : 8'h20)}, 4'h1);
    for (int ph = 0; ph < 3; ph++) begin
      if (ph == 0) ttl_in <= d2;
      if (ph == 1) set_clk(fwd, 1'b1);
      if (ph == 2) ttl_in <= d3;
      wait_n(12);
      e = exp_store(m, ph, d1, d2, d3);
      if (fwd) chk_pin("bp_line_oe_n", ~e, bp_oe_n);
      else chk_pin("ttl_out_bus", ~e, ttl_out);
    end
    set_clk(fwd, 1'b0);
  endtask
  initial begin
    logic [7:0] d, e;
    void'($urandom(44));
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    chk_pin("ttl_out_oe_n", 8'hff, ttl_oe_n);
    chk_pin("bp_line_oe_n", 8'hff, bp_oe_n);
    // Control reset, ignored writes, unmapped read
    bus(1'b1, CBT_CTRL_OFS, 32'hffff_ff25, 4'he);
    bus(1'b1, CBT_STATUS_OFS, 32'h0, 4'hf);
    bus(1'b0, CBT_CTRL_OFS, '0, 4'hf);
    chk_reg("ctrl", {24'h0, CBT_CTRL_RST}, rd);
    bus(1'b1, CBT_CTRL_OFS, 32'hffff_ff25, 4'h1);
    bus(1'b0, CBT_CTRL_OFS, '0, 4'hf);
    chk_reg("ctrl", 32'h25, rd);
    bus(1'b0, 4'hc, '0, 4'hf);
    chk_reg("unmapped", 32'h0, rd);
    // All backplane enable pairs in buffer mode, then return_path_select
    for (int k = 0; k < 5; k++) begin
      d = 8'($urandom);
      pull <= 8'($urandom);
      ttl_in <= d;
      bus(1'b1, CBT_CTRL_OFS, (k == 4) ? 32'h30 : 32'h20 | 32'(k << 6), 4'h1);
      wait_n(20);
      e = (k == 4) ? ~d : pull | ((k == 1) ? d : 8'h00);
      chk_pin("ttl_out_bus", e, ttl_out);
      chk_pin("bp_line_oe_n", (k == 1) ? ~d : 8'hff, bp_oe_n);
      chk_pin("ttl_out_oe_n", 8'h00, ttl_oe_n);
    end
    // Status shows both stores in true polarity and the filtered pins
    bus(1'b0, CBT_STATUS_OFS, '0, 4'hf);
    chk_reg("status", {~pull, d, d, d}, rd);
    // Clock enable low freezes the path; the pin change lands once it returns
    clk_en <= 1'b0;
    ttl_in <= ~d;
    wait_n(12);
    chk_pin("ttl_out_bus", ~d, ttl_out);
    clk_en <= 1'b1;
    wait_n(12);
    chk_pin("ttl_out_bus", d, ttl_out);
    for (int m = 0; m < 8; m++) begin
      run(m < 4, 2'(m));
    end
    summarize();
  end
  // Whole run is under a thousand cycles
  initial begin
    wait_n(5000);
    n_mismatch++;
    summarize();
  end
endmodule // cbt_transceiver_tb_top
`default_nettype wire
